// ---- hw/tks_capacitive_key_scan_counter.v ----
// Key scan counter: two touch modules of four keys each, with an APB register file.
// Assumes the analog sense and reference oscillators drive keyOsc and refOsc asynchronously,
// each slower than a quarter of clk, and that the pin multiplexer follows padSelect.
//
// Overview of operation
// - Each module has four key inputs, each with its own sense oscillator.
// - Module m holds keys 4m+1 to 4m+4; all modules are built alike.
// - Sense cycles are counted during a fixed slot; its end raises the interrupt.
// - With shared slot select set, module 0's slot counter times all modules.
// - One global start bit starts every module; no module has its own start.
// - Start low clears C/F, function and unit counters; slot counter keeps value.
// - Software sets the slot period by presetting the 8-bit slot counter.
// - Start rising enables oscillators together and switches on all four counters; when shared, only module 0's unit and slot counters run.
// - Slot overflow stops key and reference oscillators and all counters.
// - Slot clock is the reference oscillator when select is 0, clk/4 when 1.
// - Reference and key oscillators run only while their enable bits are set.
// - One interrupt, on overflow of all enabled modules or of module 0.
// - At the interrupt all four counters of every module are cleared.
// - Slot overflow sets a sticky flag that raises the interrupt until cleared.
// - Any module's C/F counter overflow sets a sticky flag until software clears.
// - Function counter overflow sets a sticky flag until software clears it.
// - Bit 7 of module control one picks the slot clock source.
`timescale 1ns/100ps
`include "tks_regs.vh"

module tks_capacitive_key_scan_counter (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    // Oscillators and pads
    input  wire [7:0]  keyOsc,
    input  wire [1:0]  refOsc,
    output wire [7:0]  keyOscEnable,
    output wire [1:0]  refOscEnable,
    output wire [7:0]  padSelect,
    // Interrupt
    output wire        irq
);

    localparam N = `TKS_NUM_MOD;

    // Global state.
    reg         measureStart;
    reg         sharedSlotSelect;
    reg         startPrev;
    reg         running;
    reg  [2:0]  status;
    reg  [2:0]  mask;
    reg  [1:0]  div4Cnt;
    reg  [2:0]  next_status;

    // Per-module state, flattened.
    reg  [8*N-1:0]  ctrl1;
    reg  [2*N-1:0]  senseSel;
    reg  [8*N-1:0]  slotCnt;
    reg  [32*N-1:0] result;
    reg  [N-1:0]    done;
    wire [N-1:0]    modOvf;
    wire [N-1:0]    cfOvf;
    wire [N-1:0]    fcOvf;
    wire [N-1:0]    keyActive;

    // Synchronisers for the asynchronous oscillator inputs.
    reg  [7:0]  keyS1;
    reg  [7:0]  keyS2;
    reg  [7:0]  keyS3;
    reg  [1:0]  refS1;
    reg  [1:0]  refS2;
    reg  [1:0]  refS3;
    wire [7:0]  keyEdge;
    wire [1:0]  refEdge;

    // Bus decode.
    wire        setupPhase;
    wire        wrEn;
    wire [7:0]  blk;
    wire [1:0]  modIdx;
    wire        modOk;
    reg  [31:0] rdData;
    reg         rdErr;

    wire        div4Tick;
    wire        startRise;
    wire        slotEvent;
    wire [2:0]  events;

    assign pready     = 1'b1;
    assign setupPhase = psel & ~penable;
    assign wrEn       = psel & penable & pwrite;
    assign blk        = {paddr[7:4], 4'h0};
    assign modIdx     = paddr[3:2];
    assign modOk      = (paddr[1:0] == 2'h0) && (modIdx < `TKS_MOD_LIMIT);

    always @(posedge clk) begin
        if (rst) begin
            keyS1 <= 8'h00;
            keyS2 <= 8'h00;
            keyS3 <= 8'h00;
            refS1 <= 2'h0;
            refS2 <= 2'h0;
            refS3 <= 2'h0;
        end else begin
            keyS1 <= keyOsc;
            keyS2 <= keyS1;
            keyS3 <= keyS2;
            refS1 <= refOsc;
            refS2 <= refS1;
            refS3 <= refS2;
        end
    end

    // Rising edges of the synchronised oscillators are the counted cycles.
    // The third stage only remembers the previous level; the edge logic does not read the first stage.
    assign keyEdge = keyS2 & ~keyS3;
    assign refEdge = refS2 & ~refS3;

    // Free running divider giving the system clock divided by four.
    always @(posedge clk) begin
        if (rst) begin
            div4Cnt <= 2'h0;
        end else begin
            div4Cnt <= div4Cnt + 2'h1;
        end
    end

    assign div4Tick = (div4Cnt == `TKS_DIV_LAST);

    assign startRise = measureStart & ~startPrev;

    // End of slot: module 0 alone when shared, else every module with enabled keys.
    // A module with no enabled pad must not hold the slot open, so it counts as finished.
    assign slotEvent = running & (sharedSlotSelect ? modOvf[0] : &(done | modOvf | ~keyActive));

    assign events = {|fcOvf, |cfOvf, slotEvent};

    // Global control register and measurement state.
    always @(posedge clk) begin
        if (rst) begin
            measureStart     <= 1'b0;
            sharedSlotSelect <= 1'b0;
            startPrev        <= 1'b0;
            running          <= 1'b0;
            mask             <= `TKS_RST_FLAGS;
        end else begin
            startPrev <= measureStart;
            if (wrEn && paddr == `TKS_OFF_GCTRL) begin
                measureStart     <= pwdata[`TKS_GC_START];
                sharedSlotSelect <= pwdata[`TKS_GC_SHARED];
            end
            if (wrEn && paddr == `TKS_OFF_MASK) begin
                mask <= pwdata[2:0];
            end
            // Clearing the start bit stops the slot at once; a new slot needs a fresh start edge.
            if (slotEvent || !measureStart) begin
                running <= 1'b0;
            end else if (startRise) begin
                running <= 1'b1;
            end
        end
    end

    // Sticky flags; a new event wins over a write-one-to-clear in the same cycle.
    always @* begin
        next_status = status;
        if (wrEn && paddr == `TKS_OFF_STATUS) begin
            next_status = status & ~pwdata[2:0];
        end
        next_status = next_status | events;
    end

    always @(posedge clk) begin
        if (rst) begin
            status <= `TKS_RST_FLAGS;
        end else begin
            status <= next_status;
        end
    end

    assign irq = |(status & mask);

    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : gMod
            localparam integer GI = g;
            localparam [1:0]   MI = GI[1:0];
            wire [7:0]  c1;
            wire [3:0]  kEdge;
            wire        modRun;
            wire        slotRun;
            wire        tick;
            wire        keyCount;
            wire        refCount;
            wire        wrCtrl1;
            wire        wrSlot;
            wire        wrSense;
            reg  [4:0]  unitCnt;
            reg  [15:0] cfCnt;
            reg  [15:0] fcCnt;

            assign c1      = ctrl1[8*g+:8];
            assign kEdge   = keyEdge[4*g+:4];
            assign wrCtrl1 = wrEn && modOk && blk == `TKS_OFF_CTRL1 && modIdx == MI;
            assign wrSlot  = wrEn && modOk && blk == `TKS_OFF_SLOT && modIdx == MI;
            assign wrSense = wrEn && modOk && blk == `TKS_OFF_SENSE && modIdx == MI;

            assign keyActive[g] = |c1[3:0];
            assign modRun  = running & ~done[g];
            assign slotRun = modRun & (~sharedSlotSelect | (g == 0));
            assign tick    = c1[`TKS_C1_TSS] ? div4Tick : refEdge[g];

            // Only the key picked by sense select feeds the C/F counter, and only if enabled.
            assign keyCount = modRun & c1[`TKS_C1_KOEN] & c1[senseSel[2*g+:2]] & kEdge[senseSel[2*g+:2]];
            assign refCount = modRun & c1[`TKS_C1_ROEN] & refEdge[g];

            assign modOvf[g] = slotRun & tick & (unitCnt == `TKS_UNIT_LAST) & (slotCnt[8*g+:8] == `TKS_SLOT_LAST);
            assign cfOvf[g]  = keyCount & (cfCnt == `TKS_CNT_LAST);
            assign fcOvf[g]  = refCount & (fcCnt == `TKS_CNT_LAST);

            // Oscillators run only during the slot, so all start together at the start edge.
            assign keyOscEnable[4*g+:4] = {4{modRun & c1[`TKS_C1_KOEN]}} & c1[3:0];
            assign refOscEnable[g]      = modRun & c1[`TKS_C1_ROEN];
            assign padSelect[4*g+:4]    = c1[3:0];

            always @(posedge clk) begin
                if (rst) begin
                    ctrl1[8*g+:8]    <= `TKS_RST_CTRL1;
                    senseSel[2*g+:2] <= `TKS_RST_SENSE;
                end else begin
                    if (wrCtrl1) begin
                        ctrl1[8*g+:8] <= pwdata[7:0] & `TKS_C1_WMASK;
                    end
                    if (wrSense) begin
                        senseSel[2*g+:2] <= pwdata[1:0];
                    end
                end
            end

            // A finished module idles until the next start edge while slower modules run on.
            always @(posedge clk) begin
                if (rst) begin
                    done[g] <= 1'b0;
                end else if (startRise) begin
                    done[g] <= 1'b0;
                end else if (modOvf[g]) begin
                    done[g] <= 1'b1;
                end
            end

            always @(posedge clk) begin
                if (rst) begin
                    unitCnt <= 5'h00;
                    cfCnt   <= 16'h0000;
                    fcCnt   <= 16'h0000;
                end else if (!measureStart || slotEvent) begin
                    unitCnt <= 5'h00;
                    cfCnt   <= 16'h0000;
                    fcCnt   <= 16'h0000;
                end else begin
                    if (slotRun && tick) begin
                        unitCnt <= unitCnt + 5'h01;
                    end
                    if (keyCount) begin
                        cfCnt <= cfCnt + 16'h0001;
                    end
                    if (refCount) begin
                        fcCnt <= fcCnt + 16'h0001;
                    end
                end
            end

            // The slot counter is not touched by the start bit, only by its own logic.
            always @(posedge clk) begin
                if (rst) begin
                    slotCnt[8*g+:8] <= `TKS_RST_SLOT;
                end else if (slotEvent) begin
                    slotCnt[8*g+:8] <= `TKS_RST_SLOT;
                end else if (wrSlot) begin
                    slotCnt[8*g+:8] <= pwdata[7:0];
                end else if (slotRun && tick && unitCnt == `TKS_UNIT_LAST) begin
                    slotCnt[8*g+:8] <= slotCnt[8*g+:8] + 8'h01;
                end
            end

            // Counts are kept for software before the automatic clear wipes them.
            always @(posedge clk) begin
                if (rst) begin
                    result[32*g+:32] <= 32'h00000000;
                end else if (slotEvent) begin
                    result[32*g+:32] <= {fcCnt, cfCnt};
                end
            end
        end
    endgenerate

    // Read decode; unmapped or misaligned addresses answer zero with an error.
    always @* begin
        rdData = 32'h00000000;
        rdErr  = 1'b0;
        if (paddr == `TKS_OFF_GCTRL) begin
            rdData[`TKS_GC_START]  = measureStart;
            rdData[`TKS_GC_SHARED] = sharedSlotSelect;
            rdData[`TKS_GC_BUSY]   = running;
        end else if (paddr == `TKS_OFF_STATUS) begin
            rdData[2:0] = status;
        end else if (paddr == `TKS_OFF_MASK) begin
            rdData[2:0] = mask;
        end else if (modOk && blk == `TKS_OFF_CTRL1) begin
            rdData[7:0] = ctrl1[8*modIdx+:8];
        end else if (modOk && blk == `TKS_OFF_SLOT) begin
            rdData[7:0] = slotCnt[8*modIdx+:8];
        end else if (modOk && blk == `TKS_OFF_RESULT) begin
            rdData = result[32*modIdx+:32];
        end else if (modOk && blk == `TKS_OFF_SENSE) begin
            rdData[1:0] = senseSel[2*modIdx+:2];
        end else begin
            rdErr = 1'b1;
        end
    end

    // Answer is prepared in the setup cycle so the access phase completes at once.
    always @(posedge clk) begin
        if (rst) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            prdata  <= pwrite ? 32'h00000000 : rdData;
            pslverr <= rdErr;
        end
    end

endmodule // tks_capacitive_key_scan_counter

// ---- hw/tks_regs.vh ----
// Register map, field positions, reset values and counter limits of the key scan counter.
// Assumes inclusion by the key scan counter module only; holds definitions and nothing else.
`ifndef TKS_REGS_VH
`define TKS_REGS_VH

// Structure.
`define TKS_NUM_MOD        2
`define TKS_MOD_LIMIT      2'h2
`define TKS_KEYS           8

// Byte offsets on the APB bus.
`define TKS_OFF_GCTRL      8'h00
`define TKS_OFF_STATUS     8'h04
`define TKS_OFF_MASK       8'h08
`define TKS_OFF_CTRL1      8'h10
`define TKS_OFF_SLOT       8'h20
`define TKS_OFF_RESULT     8'h30
`define TKS_OFF_SENSE      8'h40

// Global control fields.
`define TKS_GC_START       0
`define TKS_GC_SHARED      1
`define TKS_GC_BUSY        2

// Status and mask fields.
`define TKS_ST_SLOT        0
`define TKS_ST_CF          1
`define TKS_ST_FC          2

// Module control one fields.
`define TKS_C1_KOEN        4
`define TKS_C1_ROEN        5
`define TKS_C1_TSS         7
`define TKS_C1_WMASK       8'hBF

// Reset values.
`define TKS_RST_CTRL1      8'h00
`define TKS_RST_FLAGS      3'h0
`define TKS_RST_SLOT       8'h00
`define TKS_RST_SENSE      2'h0

// Counter limits and the system clock divider.
`define TKS_DIV_LAST       2'h3
`define TKS_UNIT_LAST      5'h1F
`define TKS_SLOT_LAST      8'hFF
`define TKS_CNT_LAST       16'hFFFF

`endif

// ---- verif/tks_scan_props.sv ----
// Port-level checker for the key scan counter.
// Assumes it is bound to the design top and sees only that module's ports.
`timescale 1ns/100ps

module tks_scan_props (
    // Clock and reset
    input wire        clk,
    input wire        rst,
    // APB slave
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // Oscillators and pads
    input wire [7:0]  keyOsc,
    input wire [1:0]  refOsc,
    input wire [7:0]  keyOscEnable,
    input wire [1:0]  refOscEnable,
    input wire [7:0]  padSelect,
    // Interrupt
    input wire        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wire wrAcc = psel && penable && pwrite;
    wire rdSet = psel && !penable && !pwrite;

    a_pad_follow_lo: assert property (wrAcc && paddr == 8'h10 |=>
        padSelect[3:0] == $past(pwdata[3:0])) else $error("pad select low mismatch");
    a_pad_follow_hi: assert property (wrAcc && paddr == 8'h14 |=>
        padSelect[7:4] == $past(pwdata[3:0])) else $error("pad select high mismatch");
    a_key_gated: assert property ((keyOscEnable & ~padSelect) == 8'h00 &&
        (keyOscEnable[3:0] == 4'h0 || keyOscEnable[3:0] == padSelect[3:0]) &&
        (keyOscEnable[7:4] == 4'h0 || keyOscEnable[7:4] == padSelect[7:4]))
        else $error("key oscillator runs on a non-touch pad");
    a_stop_on_clear: assert property (wrAcc && paddr == 8'h00 && !pwdata[0] |->
        ##[1:3] (keyOscEnable == 8'h00 && refOscEnable == 2'h0))
        else $error("oscillators still enabled after start cleared");
    a_start_onset: assert property ($rose(keyOscEnable[0]) |->
        $past(wrAcc && paddr == 8'h00 && pwdata[0], 2) ||
        $past(wrAcc && paddr == 8'h00 && pwdata[0], 3) ||
        $past(wrAcc && paddr == 8'h00 && pwdata[0], 4))
        else $error("key oscillator started without a start write");
    a_irq_stops_osc: assert property ($rose(irq) |->
        keyOscEnable == 8'h00 && refOscEnable == 2'h0)
        else $error("oscillators running at slot end");
    a_mask_drops_irq: assert property (wrAcc && paddr == 8'h08 && pwdata[2:0] == 3'h0 |=>
        !irq) else $error("masked interrupt still high");
    a_bit6_reads_zero: assert property (rdSet && (paddr == 8'h10 || paddr == 8'h14) |=>
        prdata[31:8] == 24'h0 && !prdata[6]) else $error("unused control bits read nonzero");
endmodule // tks_scan_props

bind tks_capacitive_key_scan_counter tks_scan_props i_tks_scan_props (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .keyOsc(keyOsc), .refOsc(refOsc),
    .keyOscEnable(keyOscEnable), .refOscEnable(refOscEnable),
    .padSelect(padSelect), .irq(irq)
);

// ---- verif/tks_osc_model.sv ----
// Behavioural sense and reference oscillators of the touch pads.
// Assumes enables come from the design; a stopped oscillator holds its level.
`timescale 1ns/100ps

module tks_osc_model #(
    parameter real KEY_HALF = 37.0,
    parameter real REF_HALF = 53.0
) (
    // Enables from the design
    input  wire logic [7:0] keyOscEnable,
    input  wire logic [1:0] refOscEnable,
    // Oscillator outputs
    output logic      [7:0] keyOsc,
    output logic      [1:0] refOsc
);
    initial begin
        keyOsc = 8'h00;
        refOsc = 2'h0;
    end
    // Each key and reference runs on its own, only while enabled.
    always #(KEY_HALF) keyOsc = keyOsc ^ keyOscEnable;
    always #(REF_HALF) refOsc = refOsc ^ refOscEnable;
endmodule // tks_osc_model

// ---- verif/tks_capacitive_key_scan_counter_tb_top.sv ----
// Self-checking bench for the key scan counter.
// Assumes the bound checker and the pad oscillator model.
`timescale 1ns/100ps

module tks_capacitive_key_scan_counter_tb_top;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, irq;
    logic [7:0]  keyOsc, keyOscEnable, padSelect;
    logic [1:0]  refOsc, refOscEnable;
    int          nMismatch = 0, testsRun = 0, cycles = 0, n, p;
    logic [7:0]  regAddr [13] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h20, 8'h24,
                                  8'h30, 8'h34, 8'h40, 8'h44, 8'h18, 8'h50};

    tks_capacitive_key_scan_counter i_tks_capacitive_key_scan_counter (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .keyOsc(keyOsc), .refOsc(refOsc),
        .keyOscEnable(keyOscEnable), .refOscEnable(refOscEnable),
        .padSelect(padSelect), .irq(irq));
    tks_osc_model i_tks_osc_model (.keyOscEnable(keyOscEnable),
        .refOscEnable(refOscEnable), .keyOsc(keyOsc), .refOsc(refOsc));

    always #5 clk = ~clk;

    task summarize;
        if (nMismatch == 0 && testsRun > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            $display("[ERR] %0t got %h cycles exp below %h", $time, cycles, 60000);
            nMismatch++;
            summarize();
        end
    end

    task chk(input logic [31:0] g, input logic [31:0] e);
        testsRun++;
        if (g !== e) begin
            nMismatch++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
        testsRun++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            nMismatch++;
            $display("[ERR] %0t got %h exp %h..%h", $time, g, lo, hi);
        end
    endtask

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    // One measurement: configure, start, wait for the slot end, then check flags.
    task run(input logic sh, input logic [7:0] c0, input logic [7:0] c1,
             input logic [7:0] s0, input logic [7:0] s1);
        xfer(1, 8'h00, 32'h0);
        xfer(1, 8'h10, {24'h0, c0});
        xfer(1, 8'h14, {24'h0, c1});
        xfer(1, 8'h20, {24'h0, s0});
        xfer(1, 8'h24, {24'h0, s1});
        xfer(1, 8'h00, {30'h0, sh, 1'b1});
        n = 0;
        while (irq !== 1'b1 && n < 9000) begin
            @(posedge clk);
            n++;
        end
        chk(irq, 1);
        xfer(0, 8'h04, 0); chk(rd, 1);
        xfer(0, 8'h00, 0); chk(rd[2], 0);
        xfer(0, 8'h20, 0); chk(rd, 0);
        xfer(1, 8'h08, 0); #1 chk(irq, 0);
        xfer(1, 8'h08, 7); #1 chk(irq, 1);
        xfer(1, 8'h04, 1); #1 chk(irq, 0);
    endtask

    initial begin
        void'($urandom(32'hFC91));
        repeat (5) @(posedge clk);
        rst <= 0;
        foreach (regAddr[i]) begin
            xfer(0, regAddr[i], 0);
            chk(rd, 0);
            chk(er, i > 10);
        end
        for (int m = 0; m < 2; m++) begin
            p = $urandom;
            xfer(1, 8'h10 + 8'(4 * m), p);
            xfer(0, 8'h10 + 8'(4 * m), 0);
            chk(rd, p & 32'hBF);
            chk(padSelect[4*m +: 4], p[3:0]);
        end
        xfer(1, 8'h20, 32'hAB);
        xfer(0, 8'h20, 0); chk(rd, 32'hAB);
        xfer(1, 8'h08, 7);
        p = 8'hF8 | ($urandom % 8);
        run(0, 8'h91, 8'h00, 8'(p), 8'h00);
        rng(n, (256 - p) * 128 - 1, (256 - p) * 128 + 2);
        for (int sh = 0; sh < 2; sh++) begin
            run(1'(sh), 8'h91, 8'h81, 8'hFF, 8'hFE);
            rng(n, (sh ? 128 : 256) - 1, (sh ? 128 : 256) + 2);
        end
        xfer(1, 8'h40, 2);
        xfer(0, 8'h40, 0);
        chk(rd, 2);
        run(0, 8'h35, 8'h00, 8'hFF, 8'h00);
        rng(n, 333, 338);
        xfer(0, 8'h30, 0);
        rng(rd[31:16], 30, 34);
        rng(rd[15:0], n * 10 / 74 - 3, n * 10 / 74 + 3);
        xfer(0, 8'h34, 0);
        chk(rd, 0);
        summarize();
    end
endmodule // tks_capacitive_key_scan_counter_tb_top
